/* File: rtl/sdrbs_pkg.sv */
// Shared constants and types for the refresh and bank state block
`default_nettype none
package sdrbs_pkg;
	// Command codes, {ras_n, cas_n, we_n} with chip select low
	localparam logic [2:0] CMD_NOP       = 3'h7;
	localparam logic [2:0] CMD_ACTIVE    = 3'h3;
	localparam logic [2:0] CMD_READ      = 3'h5;
	localparam logic [2:0] CMD_WRITE     = 3'h4;
	localparam logic [2:0] CMD_BURST_END = 3'h6;
	localparam logic [2:0] CMD_PRECHARGE = 3'h2;
	localparam logic [2:0] CMD_REFRESH   = 3'h1;
	localparam logic [2:0] CMD_MODE_LOAD = 3'h0;
	// Field position and sizes
	localparam int AUTO_PRECHARGE_BIT = 10;
	localparam int NUM_BANKS          = 4;
	localparam int ROW_BITS           = 13;
	localparam int TIMER_BITS         = 16;
	// Timing, ns, and derived cycle counts at 100 MHz
	localparam int CLK_PERIOD_NS            = 10;
	localparam int PRECHARGE_PERIOD_NS      = 20;
	localparam int ROW_TO_COLUMN_DELAY_NS   = 20;
	localparam int REFRESH_CYCLE_TIME_NS    = 66;
	localparam int MODE_LOAD_DELAY_NS       = 20;
	localparam int SELF_REFRESH_EXIT_NS     = 75;
	localparam int SELF_REFRESH_EXIT_MIN_CK = 2;
	localparam int INTERNAL_REFRESH_NS      = 7813;
	// Least times round up
	localparam int PRECHARGE_CYC = (PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ROW_TO_COLUMN_CYC =
		(ROW_TO_COLUMN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REFRESH_CYC = (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MODE_LOAD_CYC = (MODE_LOAD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXIT_RAW_CYC = (SELF_REFRESH_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SELF_REFRESH_EXIT_CYC =
		(EXIT_RAW_CYC > SELF_REFRESH_EXIT_MIN_CK) ? EXIT_RAW_CYC : SELF_REFRESH_EXIT_MIN_CK;
	// Longest time rounds down
	localparam int INTERNAL_REFRESH_CYC = INTERNAL_REFRESH_NS / CLK_PERIOD_NS;

	// Per-bank state
	typedef enum logic [2:0]
	{
		SDRBS_IDLE,
		SDRBS_ACTIVATING,
		SDRBS_ROW_ACTIVE,
		SDRBS_READ,
		SDRBS_WRITE,
		SDRBS_READ_AP,
		SDRBS_WRITE_AP,
		SDRBS_PRECHARGING
	} sdrbs_bank_t;

	// Device-wide state
	typedef enum logic [2:0]
	{
		SDRBS_DEV_NORMAL,
		SDRBS_DEV_REFRESHING,
		SDRBS_DEV_MODE_LOAD,
		SDRBS_DEV_PRE_ALL,
		SDRBS_DEV_SELF_REFRESH,
		SDRBS_DEV_SR_EXIT
	} sdrbs_dev_t;
endpackage : sdrbs_pkg
`default_nettype wire

/* File: rtl/sdrbs_bank_if.sv */
// Interface carrying per-bank command strobes to the bank trackers
`timescale 1ns/1ps
`default_nettype none
interface sdrbs_bank_if;
	logic        activate;
	logic        read;
	logic        write;
	logic        auto_pre;
	logic        precharge;
	logic        burst_stop;
	logic [2:0]  state;
	logic        busy;

	modport ctrl
	(
		output activate, read, write, auto_pre, precharge, burst_stop,
		input  state, busy
	);
	modport bank
	(
		input  activate, read, write, auto_pre, precharge, burst_stop,
		output state, busy
	);
endinterface : sdrbs_bank_if
`default_nettype wire

/* File: rtl/sdrbs_bank.sv */
// One bank's current-state tracker with its timed states
`timescale 1ns/1ps
`default_nettype none
module sdrbs_bank
(
	input  wire logic core_clk_i,
	input  wire logic resetn_i,
	input  wire logic burst_done_i,
	sdrbs_bank_if.bank bus
);
	sdrbs_pkg::sdrbs_bank_t state_ff;
	logic [7:0]             timer_ff;

	assign bus.state = state_ff;
	assign bus.busy  = (state_ff != sdrbs_pkg::SDRBS_IDLE);

	////////////////////////////////////////////////////////////////
	// Bank state; no strobe means the operation keeps running
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_ff <= sdrbs_pkg::SDRBS_IDLE;
			timer_ff <= 8'h00;
		end
		else
		begin
			if (timer_ff != 8'h00)
				timer_ff <= timer_ff - 8'h01;
			case (state_ff)
				sdrbs_pkg::SDRBS_IDLE:
				begin
					// Precharge to an idle bank is ignored
					if (bus.activate)
					begin
						state_ff <= sdrbs_pkg::SDRBS_ACTIVATING;
						timer_ff <= 8'(sdrbs_pkg::ROW_TO_COLUMN_CYC - 1);
					end
				end
				sdrbs_pkg::SDRBS_ACTIVATING:
				begin
					if (timer_ff == 8'h00)
						state_ff <= sdrbs_pkg::SDRBS_ROW_ACTIVE;
				end
				sdrbs_pkg::SDRBS_ROW_ACTIVE, sdrbs_pkg::SDRBS_READ,
				sdrbs_pkg::SDRBS_WRITE:
				begin
					// New access restarts, precharge truncates
					if (bus.precharge)
					begin
						state_ff <= sdrbs_pkg::SDRBS_PRECHARGING;
						timer_ff <= 8'(sdrbs_pkg::PRECHARGE_CYC - 1);
					end
					else if (bus.read || bus.write)
					begin
						if (bus.auto_pre)
						begin
							state_ff <= bus.read ? sdrbs_pkg::SDRBS_READ_AP
								: sdrbs_pkg::SDRBS_WRITE_AP;
							timer_ff <= 8'(sdrbs_pkg::PRECHARGE_CYC - 1);
						end
						else
							state_ff <= bus.read ? sdrbs_pkg::SDRBS_READ
								: sdrbs_pkg::SDRBS_WRITE;
					end
					else if (bus.burst_stop || burst_done_i)
					begin
						if (state_ff != sdrbs_pkg::SDRBS_ROW_ACTIVE)
							state_ff <= sdrbs_pkg::SDRBS_ROW_ACTIVE;
					end
				end
				sdrbs_pkg::SDRBS_READ_AP, sdrbs_pkg::SDRBS_WRITE_AP,
				sdrbs_pkg::SDRBS_PRECHARGING:
				begin
					// Simplification: burst length folded into the precharge wait
					if (timer_ff == 8'h00)
						state_ff <= sdrbs_pkg::SDRBS_IDLE;
				end
				default:
					state_ff <= sdrbs_pkg::SDRBS_IDLE;
			endcase
		end
	end
endmodule : sdrbs_bank
`default_nettype wire

/* File: rtl/sdrbs_top.sv */
// Refresh handling and per-bank command tracking of a four-bank SDRAM
`timescale 1ns/1ps
`default_nettype none
module sdrbs_top
#(
	parameter int  BURST_CYCLES     = 4,
	parameter bit  AUTOMOTIVE_GRADE = 1'b0,
	parameter int  INTERNAL_REF_CYC = sdrbs_pkg::INTERNAL_REFRESH_CYC
)
(
	input  wire logic        core_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        clk_gate_i,
	input  wire logic        chip_sel_n_i,
	input  wire logic        row_strobe_n_i,
	input  wire logic        col_strobe_n_i,
	input  wire logic        write_strobe_n_i,
	input  wire logic [12:0] addr_i,
	input  wire logic        bank_select_low_i,
	input  wire logic        bank_select_high_i,
	output logic [11:0]      bank_state_o,
	output logic [2:0]       dev_state_o,
	output logic [12:0]      refresh_row_o,
	output logic             refresh_pulse_o,
	output logic             cmd_error_o
);
	////////////////////////////////////////////////////////////////
	// Pin synchronisers: two flops before any logic
	logic [18:0] pin_s1_ff;
	logic [18:0] pin_s2_ff;
	logic        gate_prev_ff;

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pin_s1_ff <= {1'b0, 4'hf, 14'h0000};
			pin_s2_ff <= {1'b0, 4'hf, 14'h0000};
		end
		else
		begin
			pin_s1_ff <= {clk_gate_i, chip_sel_n_i, row_strobe_n_i, col_strobe_n_i,
				write_strobe_n_i, addr_i, bank_select_high_i};
			pin_s2_ff <= pin_s1_ff;
		end
	end

	logic        bank_lo_s1_ff;
	logic        bank_lo_s2_ff;
	logic        gate;
	logic        cs_n;
	logic [2:0]  cmd;
	logic        ap_bit;
	logic [1:0]  bank_sel;

	assign gate     = pin_s2_ff[18];
	assign cs_n     = pin_s2_ff[17];
	assign cmd      = pin_s2_ff[16:14];
	assign ap_bit   = pin_s2_ff[1 + sdrbs_pkg::AUTO_PRECHARGE_BIT];
	assign bank_sel = {pin_s2_ff[0], bank_lo_s2_ff};

	// Low bank select gets its own synchroniser pair
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			bank_lo_s1_ff <= 1'b0;
			bank_lo_s2_ff <= 1'b0;
			gate_prev_ff  <= 1'b0;
		end
		else
		begin
			bank_lo_s1_ff <= bank_select_low_i;
			bank_lo_s2_ff <= bank_lo_s1_ff;
			gate_prev_ff  <= gate;
		end
	end

	////////////////////////////////////////////////////////////////
	// Command decode, gated by device state
	sdrbs_pkg::sdrbs_dev_t dev_ff;
	logic [15:0]           dev_timer_ff;
	logic                  cmd_valid;
	logic                  all_idle;
	logic                  dev_free;
	logic [3:0]            bank_busy;

	function automatic logic is_cmd(input logic [2:0] c, input logic [2:0] code);
		is_cmd = (c == code);
	endfunction : is_cmd

	assign dev_free  = (dev_ff == sdrbs_pkg::SDRBS_DEV_NORMAL);
	// Decode only with gate high now and last cycle, exit time done
	assign cmd_valid = dev_free && gate && gate_prev_ff && !cs_n;
	assign all_idle  = (bank_busy == 4'h0);

	////////////////////////////////////////////////////////////////
	// Bank trackers
	sdrbs_bank_if bif[sdrbs_pkg::NUM_BANKS]();
	logic [11:0]  bank_state_all;
	logic [1:0]   last_burst_ff;
	logic [7:0]   burst_cnt_ff;
	logic         burst_live_ff;

	genvar gi;
	generate
		for (gi = 0; gi < sdrbs_pkg::NUM_BANKS; gi++)
		begin : g_bank
			logic hit;
			assign hit = (bank_sel == 2'(gi));
			assign bif[gi].activate  = cmd_valid && is_cmd(cmd, sdrbs_pkg::CMD_ACTIVE) && hit;
			assign bif[gi].read      = cmd_valid && is_cmd(cmd, sdrbs_pkg::CMD_READ) && hit;
			assign bif[gi].write     = cmd_valid && is_cmd(cmd, sdrbs_pkg::CMD_WRITE) && hit;
			assign bif[gi].auto_pre  = ap_bit;
			// Bit high: all banks, bank select ignored
			assign bif[gi].precharge = cmd_valid && is_cmd(cmd, sdrbs_pkg::CMD_PRECHARGE)
				&& (ap_bit || hit);
			// Terminate goes to the bank of the latest burst
			assign bif[gi].burst_stop = cmd_valid && is_cmd(cmd, sdrbs_pkg::CMD_BURST_END)
				&& (last_burst_ff == 2'(gi));
			assign bank_busy[gi] = bif[gi].busy;

			sdrbs_bank u_bank
			(
				.core_clk_i   (core_clk_i),
				.resetn_i     (resetn_i),
				.burst_done_i (burst_live_ff && burst_cnt_ff == 8'h00
					&& last_burst_ff == 2'(gi)),
				.bus          (bif[gi])
			);

			assign bank_state_all[3*gi +: 3] = bif[gi].state;
		end
	endgenerate

	// One register stage for all bank states, so the output has one driver
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			bank_state_o <= 12'h000;
		else
			bank_state_o <= bank_state_all;
	end

	// Most recent burst owner and a fixed-length burst counter
	logic access;
	assign access = cmd_valid && (is_cmd(cmd, sdrbs_pkg::CMD_READ)
		|| is_cmd(cmd, sdrbs_pkg::CMD_WRITE));

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			last_burst_ff <= 2'h0;
			burst_cnt_ff  <= 8'h00;
			burst_live_ff <= 1'b0;
		end
		else if (access)
		begin
			last_burst_ff <= bank_sel;
			burst_cnt_ff  <= 8'(BURST_CYCLES - 1);
			burst_live_ff <= 1'b1;
		end
		else if (cmd_valid && is_cmd(cmd, sdrbs_pkg::CMD_BURST_END))
			burst_live_ff <= 1'b0;
		else if (burst_live_ff)
		begin
			if (burst_cnt_ff == 8'h00)
				burst_live_ff <= 1'b0;
			else
				burst_cnt_ff <= burst_cnt_ff - 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////
	// Device state: refresh, mode load, precharge all, self refresh
	logic refresh_cmd;
	logic sr_enter;
	logic internal_tick;

	// Refresh encoding; gate sampled this cycle chooses auto or self
	assign refresh_cmd = dev_free && gate_prev_ff && !cs_n
		&& is_cmd(cmd, sdrbs_pkg::CMD_REFRESH) && all_idle;
	// Automotive build never enters self refresh
	assign sr_enter = refresh_cmd && !gate && !AUTOMOTIVE_GRADE;

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			dev_ff       <= sdrbs_pkg::SDRBS_DEV_NORMAL;
			dev_timer_ff <= 16'h0000;
		end
		else
		begin
			case (dev_ff)
				sdrbs_pkg::SDRBS_DEV_NORMAL:
				begin
					if (sr_enter)
						dev_ff <= sdrbs_pkg::SDRBS_DEV_SELF_REFRESH;
					else if (refresh_cmd && gate)
					begin
						dev_ff       <= sdrbs_pkg::SDRBS_DEV_REFRESHING;
						dev_timer_ff <= 16'(sdrbs_pkg::REFRESH_CYC - 1);
					end
					else if (cmd_valid && all_idle && is_cmd(cmd, sdrbs_pkg::CMD_MODE_LOAD))
					begin
						dev_ff       <= sdrbs_pkg::SDRBS_DEV_MODE_LOAD;
						dev_timer_ff <= 16'(sdrbs_pkg::MODE_LOAD_CYC - 1);
					end
					else if (cmd_valid && ap_bit && is_cmd(cmd, sdrbs_pkg::CMD_PRECHARGE))
					begin
						dev_ff       <= sdrbs_pkg::SDRBS_DEV_PRE_ALL;
						dev_timer_ff <= 16'(sdrbs_pkg::PRECHARGE_CYC - 1);
					end
				end
				sdrbs_pkg::SDRBS_DEV_REFRESHING, sdrbs_pkg::SDRBS_DEV_MODE_LOAD,
				sdrbs_pkg::SDRBS_DEV_PRE_ALL, sdrbs_pkg::SDRBS_DEV_SR_EXIT:
				begin
					// Inputs ignored until the interval runs out
					if (dev_timer_ff == 16'h0000)
						dev_ff <= sdrbs_pkg::SDRBS_DEV_NORMAL;
					else
						dev_timer_ff <= dev_timer_ff - 16'h0001;
				end
				sdrbs_pkg::SDRBS_DEV_SELF_REFRESH:
				begin
					// Only the clock gate is watched here
					if (gate)
					begin
						dev_ff       <= sdrbs_pkg::SDRBS_DEV_SR_EXIT;
						dev_timer_ff <= 16'(sdrbs_pkg::SELF_REFRESH_EXIT_CYC - 1);
					end
				end
				default:
					dev_ff <= sdrbs_pkg::SDRBS_DEV_NORMAL;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Internal refresh timer for self refresh; models the on-die oscillator
	logic [15:0] int_cnt_ff;
	assign internal_tick = (dev_ff == sdrbs_pkg::SDRBS_DEV_SELF_REFRESH)
		&& (int_cnt_ff == 16'h0000);

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			int_cnt_ff <= 16'h0000;
		else if (dev_ff != sdrbs_pkg::SDRBS_DEV_SELF_REFRESH)
			int_cnt_ff <= 16'(INTERNAL_REF_CYC - 1);
		else if (int_cnt_ff == 16'h0000)
			int_cnt_ff <= 16'(INTERNAL_REF_CYC - 1);
		else
			int_cnt_ff <= int_cnt_ff - 16'h0001;
	end

	////////////////////////////////////////////////////////////////
	// Shared row counter; both refresh modes advance it, address ignored
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			refresh_row_o   <= 13'h0000;
			refresh_pulse_o <= 1'b0;
		end
		else
		begin
			refresh_pulse_o <= (refresh_cmd && gate) || internal_tick;
			if ((refresh_cmd && gate) || internal_tick)
				refresh_row_o <= refresh_row_o + 13'h0001;
		end
	end

	////////////////////////////////////////////////////////////////
	// Status outputs; with the gate high, error flags commands a busy device rejects, and refresh or mode load with a bank open
	logic bad_cmd;
	assign bad_cmd = !cs_n && gate && gate_prev_ff && !is_cmd(cmd, sdrbs_pkg::CMD_NOP)
		&& (!dev_free
		|| ((is_cmd(cmd, sdrbs_pkg::CMD_REFRESH) || is_cmd(cmd, sdrbs_pkg::CMD_MODE_LOAD))
		&& !all_idle));

	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			dev_state_o <= 3'h0;
			cmd_error_o <= 1'b0;
		end
		else
		begin
			dev_state_o <= dev_ff;
			cmd_error_o <= bad_cmd;
		end
	end
endmodule : sdrbs_top
`default_nettype wire

/* File: dv/sdrbs_top_properties.sv */
// Checker of timed states and refresh behaviour at the block ports
`timescale 1ns/1ps
`default_nettype none
module sdrbs_chk
#(
	parameter bit AUTOMOTIVE_GRADE = 1'b0,
	parameter int INTERNAL_REF_CYC = 781
)
(
	input wire logic        core_clk_i,
	input wire logic        resetn_i,
	input wire logic        clk_gate_i,
	input wire logic [11:0] bank_state_o,
	input wire logic [2:0]  dev_state_o,
	input wire logic [12:0] refresh_row_o,
	input wire logic        refresh_pulse_o,
	input wire logic        cmd_error_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	logic [15:0] sr_cnt_ff;
	logic [2:0]  b0;
	assign b0 = bank_state_o[2:0];
	////////////////////////////////////////////////////////////////
	// Cycles since last internal refresh, only counted in self refresh
	always_ff @(posedge core_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			sr_cnt_ff <= 16'h0;
		else if (refresh_pulse_o || dev_state_o != 3'h4)
			sr_cnt_ff <= 16'h0;
		else
			sr_cnt_ff <= sr_cnt_ff + 16'h1;
	end
	////////////////////////////////////////////////////////////////
	// Entry into a two-cycle bank state, then the state that follows
	property p_bank2(s, nx);
		b0 == s && $past(b0) != s |-> (b0 == s)[*2] ##1 b0 == nx;
	endproperty
	a_activate_time: assert property (p_bank2(3'h1, 3'h2))
		else $error("activating state length wrong");
	a_precharge_time: assert property (p_bank2(3'h7, 3'h0))
		else $error("precharging state length wrong");
	a_read_ap_time: assert property (p_bank2(3'h5, 3'h0))
		else $error("read with auto precharge length wrong");
	a_refresh_time: assert property (dev_state_o == 3'h1 && $past(dev_state_o) != 3'h1
		|-> (dev_state_o == 3'h1)[*7] ##1 dev_state_o == 3'h0) else $error("refresh length wrong");
	a_mode_load_time: assert property (dev_state_o == 3'h2 && $past(dev_state_o) != 3'h2
		|-> (dev_state_o == 3'h2)[*2] ##1 dev_state_o == 3'h0) else $error("mode load length wrong");
	a_exit_time: assert property (dev_state_o == 3'h5 && $past(dev_state_o) != 3'h5
		|-> (dev_state_o == 3'h5)[*8] ##1 dev_state_o == 3'h0) else $error("exit length wrong");
	a_all_idle_after: assert property ($past(dev_state_o) inside {3'h1, 3'h2, 3'h3}
		&& dev_state_o == 3'h0 |-> bank_state_o == 12'h0) else $error("banks not idle");
	a_row_steps_one: assert property ($changed(refresh_row_o)
		|-> refresh_row_o == $past(refresh_row_o) + 13'h1) else $error("row counter jump");
	a_pulse_once: assert property (refresh_pulse_o |=> !refresh_pulse_o)
		else $error("refresh pulse too long");
	a_sr_holds: assert property (dev_state_o == 3'h4 && !clk_gate_i && !$past(clk_gate_i)
		|=> dev_state_o == 3'h4 && $stable(bank_state_o)) else $error("self refresh left");
	a_sr_refreshes: assert property (sr_cnt_ff <= 16'(INTERNAL_REF_CYC) + 16'h2)
		else $error("no internal refresh");
	a_no_sr_auto: assert property (AUTOMOTIVE_GRADE |-> dev_state_o != 3'h4)
		else $error("self refresh on automotive grade");
	c_refresh: cover property (dev_state_o == 3'h1);
	c_exit: cover property (dev_state_o == 3'h5);
	c_error: cover property (cmd_error_o);
	c_read: cover property (b0 == 3'h3);
endmodule : sdrbs_chk
bind sdrbs_top sdrbs_chk
#(
	.AUTOMOTIVE_GRADE(AUTOMOTIVE_GRADE),
	.INTERNAL_REF_CYC(INTERNAL_REF_CYC)
) u_chk
(
	.core_clk_i      (core_clk_i),
	.resetn_i        (resetn_i),
	.clk_gate_i      (clk_gate_i),
	.bank_state_o    (bank_state_o),
	.dev_state_o     (dev_state_o),
	.refresh_row_o   (refresh_row_o),
	.refresh_pulse_o (refresh_pulse_o),
	.cmd_error_o     (cmd_error_o)
);
`default_nettype wire

/* File: dv/sdrbs_ctrl_model.sv */
// Memory controller model driving the command pins
`timescale 1ns/1ps
`default_nettype none
module sdrbs_ctrl_model
(
	input  wire logic        core_clk_i,
	input  wire logic [12:0] noise_i,
	output logic             clk_gate_o,
	output logic             chip_sel_n_o,
	output logic [2:0]       cmd_o,
	output logic [12:0]      addr_o,
	output logic [1:0]       bank_o
);
	logic ap_ff = 1'b0;
	initial
	begin
		clk_gate_o = 1'b1;
		chip_sel_n_o = 1'b1;
		cmd_o = sdrbs_pkg::CMD_NOP;
		bank_o = 2'h0;
	end
	// Unused address bits take new random values every cycle; the row must not follow them
	assign addr_o = {noise_i[12:11], ap_ff, noise_i[9:0]};
	////////////////////////////////////////////////////////////////
	// One command for one edge, then deselect or NOP at random
	task issue(input logic [2:0] c, input logic ap, input logic [1:0] b, input logic g);
		@(posedge core_clk_i);
		cmd_o <= c;
		chip_sel_n_o <= 1'b0;
		ap_ff <= ap;
		bank_o <= b;
		clk_gate_o <= g;
		@(posedge core_clk_i);
		cmd_o <= sdrbs_pkg::CMD_NOP;
		chip_sel_n_o <= noise_i[0];
		bank_o <= noise_i[2:1];
	endtask : issue
	// Gate raised with the clock already running, then only NOPs
	task set_gate(input logic g);
		@(posedge core_clk_i);
		clk_gate_o <= g;
	endtask : set_gate
	////////////////////////////////////////////////////////////////
	// Refresh interval counter; distributed refresh, not one long burst of them
	int gap     = 0;
	int max_gap = 0;
	always @(posedge core_clk_i)
	begin
		if (!chip_sel_n_o && cmd_o == sdrbs_pkg::CMD_REFRESH)
			gap <= 0;
		else
			gap <= gap + 1;
		if (gap > max_gap)
			max_gap <= gap;
	end
endmodule : sdrbs_ctrl_model
`default_nettype wire

/* File: dv/sdrbs_top_bench.sv */
// Self-checking bench of the refresh and bank state block
`timescale 1ns/1ps
`default_nettype none
module sdrbs_top_bench;
	logic        core_clk_i = 1'b0;
	logic        resetn_i   = 1'b0;
	logic [12:0] noise      = 13'h0;
	logic [31:0] seed       = 32'h579a997e;
	wire logic        gate, csn, pulse, err;
	wire logic [2:0]  cmd, dst, dst_a;
	wire logic [12:0] addr, row;
	wire logic [1:0]  ba;
	wire logic [11:0] bst;
	int fail_count = 0;
	int n_checks   = 0;
	int pulses     = 0;
	int errs       = 0;
	int cyc        = 0;
	always #5 core_clk_i = ~core_clk_i;
	sdrbs_ctrl_model u_ctrl (.core_clk_i(core_clk_i), .noise_i(noise), .clk_gate_o(gate),
		.chip_sel_n_o(csn), .cmd_o(cmd), .addr_o(addr), .bank_o(ba));
	// Long burst so only a terminate ends it early
	sdrbs_top #(.BURST_CYCLES(32), .INTERNAL_REF_CYC(10)) dut (.core_clk_i(core_clk_i),
		.resetn_i(resetn_i), .clk_gate_i(gate), .chip_sel_n_i(csn), .row_strobe_n_i(cmd[2]),
		.col_strobe_n_i(cmd[1]), .write_strobe_n_i(cmd[0]), .addr_i(addr),
		.bank_select_low_i(ba[0]), .bank_select_high_i(ba[1]), .bank_state_o(bst),
		.dev_state_o(dst), .refresh_row_o(row), .refresh_pulse_o(pulse), .cmd_error_o(err));
	sdrbs_top #(.AUTOMOTIVE_GRADE(1'b1), .INTERNAL_REF_CYC(10)) dut_auto (.core_clk_i(core_clk_i),
		.resetn_i(resetn_i), .clk_gate_i(gate), .chip_sel_n_i(csn), .row_strobe_n_i(cmd[2]),
		.col_strobe_n_i(cmd[1]), .write_strobe_n_i(cmd[0]), .addr_i(addr),
		.bank_select_low_i(ba[0]), .bank_select_high_i(ba[1]), .bank_state_o(),
		.dev_state_o(dst_a), .refresh_row_o(), .refresh_pulse_o(), .cmd_error_o());
	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction : xs
	// Index 4 selects the device state, 0 to 3 a bank
	function automatic logic [2:0] sel(input int b);
		return (b == 4) ? dst : bst[b*3 +: 3];
	endfunction : sel
	function automatic logic [2:0] exp_acc(input logic [2:0] c, input logic ap);
		if (c == sdrbs_pkg::CMD_READ)
			return ap ? 3'h5 : 3'h3;
		return ap ? 3'h6 : 3'h4;
	endfunction : exp_acc
	task chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Bounded poll; short states are caught because it looks every cycle
	task settle(input int b, input logic [2:0] st);
		repeat (14)
		begin
			#1;
			if (sel(b) === st)
				break;
			@(posedge core_clk_i);
		end
		chk("state", 13'(sel(b)), 13'(st));
	endtask : settle
	task end_of_test();
		if (fail_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////
	// Noise, pulse counting and the hang limit
	always @(posedge core_clk_i)
	begin
		noise <= seed[12:0];
		seed <= xs(seed);
		cyc++;
		if (pulse === 1'b1)
			pulses++;
		if (err === 1'b1)
			errs++;
		if (cyc == 20000)
		begin
			fail_count++;
			end_of_test();
		end
	end
	initial
	begin
		logic [1:0]  b;
		logic [2:0]  c;
		logic [12:0] r0;
		int          p0;
		int          e0;
		repeat (5) @(posedge core_clk_i);
		chk("reset", {bst, pulse}, 13'h0);
		chk("reset_dev", {dst, row[9:0]}, 13'h0);
		resetn_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		// Odd passes aim at bank 0, so the checker sees its auto precharge timing
		for (int k = 0; k < 4; k++)
		begin
			b = k[0] ? 2'h0 : seed[1:0];
			c = k[1] ? sdrbs_pkg::CMD_WRITE : sdrbs_pkg::CMD_READ;
			u_ctrl.issue(sdrbs_pkg::CMD_ACTIVE, 1'b0, b, 1'b1);
			settle(b, 3'h1);
			settle(b, 3'h2);
			u_ctrl.issue(c, k[0], b, 1'b1);
			settle(b, exp_acc(c, k[0]));
			if (!k[0])
				u_ctrl.issue(sdrbs_pkg::CMD_PRECHARGE, 1'b0, b, 1'b1);
			if (!k[0])
				settle(b, 3'h7);
			settle(b, 3'h0);
			e0 = errs;
			u_ctrl.issue(sdrbs_pkg::CMD_PRECHARGE, 1'b0, b, 1'b1);
			repeat (6) @(posedge core_clk_i);
			chk("idle_pre", {10'h0, sel(b)}, 13'h0);
			chk("idle_pre_err", 13'(errs - e0), 13'h0);
		end
		// Back-to-back reads restart, terminate aimed at another bank
		u_ctrl.issue(sdrbs_pkg::CMD_ACTIVE, 1'b0, 2'h2, 1'b1);
		settle(2, 3'h2);
		u_ctrl.issue(sdrbs_pkg::CMD_READ, 1'b0, 2'h2, 1'b1);
		u_ctrl.issue(sdrbs_pkg::CMD_READ, 1'b0, 2'h2, 1'b1);
		settle(2, 3'h3);
		u_ctrl.issue(sdrbs_pkg::CMD_BURST_END, 1'b0, 2'h1, 1'b1);
		settle(2, 3'h2);
		u_ctrl.issue(sdrbs_pkg::CMD_ACTIVE, 1'b0, 2'h0, 1'b1);
		settle(0, 3'h2);
		// A burst left alone runs its full length, then the row stays open
		u_ctrl.issue(sdrbs_pkg::CMD_WRITE, 1'b0, 2'h0, 1'b1);
		settle(0, 3'h4);
		repeat (36) @(posedge core_clk_i);
		chk("burst_end", {10'h0, sel(0)}, 13'h2);
		u_ctrl.issue(sdrbs_pkg::CMD_PRECHARGE, 1'b1, seed[1:0], 1'b1);
		settle(4, 3'h3);
		settle(4, 3'h0);
		chk("pre_all", {1'b0, bst}, 13'h0);
		// Refresh with an open bank is refused
		u_ctrl.issue(sdrbs_pkg::CMD_ACTIVE, 1'b0, 2'h1, 1'b1);
		settle(1, 3'h2);
		e0 = errs;
		p0 = pulses;
		u_ctrl.issue(sdrbs_pkg::CMD_REFRESH, 1'b0, 2'h0, 1'b1);
		repeat (6) @(posedge core_clk_i);
		chk("busy_refresh", 13'(pulses - p0), 13'h0);
		chk("busy_refresh_err", 13'(errs - e0), 13'h1);
		u_ctrl.issue(sdrbs_pkg::CMD_PRECHARGE, 1'b0, 2'h1, 1'b1);
		settle(1, 3'h0);
		r0 = row;
		p0 = pulses;
		e0 = errs;
		u_ctrl.issue(sdrbs_pkg::CMD_REFRESH, 1'b0, 2'h0, 1'b1);
		settle(4, 3'h1);
		u_ctrl.issue(sdrbs_pkg::CMD_ACTIVE, 1'b0, 2'h3, 1'b1);
		settle(4, 3'h0);
		chk("refresh_pulse", 13'(pulses - p0), 13'h1);
		chk("refresh_row", row, r0 + 13'h1);
		chk("refresh_block", 13'(errs - e0), 13'h1);
		chk("refresh_bank3", {10'h0, sel(3)}, 13'h0);
		u_ctrl.issue(sdrbs_pkg::CMD_MODE_LOAD, 1'b0, 2'h0, 1'b1);
		settle(4, 3'h2);
		settle(4, 3'h0);
		// Self refresh: inputs ignored while gate stays low
		p0 = pulses;
		u_ctrl.issue(sdrbs_pkg::CMD_REFRESH, 1'b0, 2'h0, 1'b0);
		settle(4, 3'h4);
		u_ctrl.issue(sdrbs_pkg::CMD_ACTIVE, 1'b0, 2'h0, 1'b0);
		repeat (40) @(posedge core_clk_i);
		chk("sr_ignore", {10'h0, sel(0)}, 13'h0);
		chk("sr_refresh", 13'(pulses - p0 >= 3), 13'h1);
		chk("auto_grade", 13'(dst_a == 3'h4), 13'h0);
		u_ctrl.set_gate(1'b1);
		settle(4, 3'h5);
		settle(4, 3'h0);
		u_ctrl.issue(sdrbs_pkg::CMD_REFRESH, 1'b0, 2'h0, 1'b1);
		settle(4, 3'h1);
		settle(4, 3'h0);
		// Stimulus kept within the distributed refresh interval throughout
		p0 = u_ctrl.max_gap;
		chk("refresh_gap", 13'(p0 <= sdrbs_pkg::INTERNAL_REFRESH_CYC), 13'h1);
		end_of_test();
	end
endmodule : sdrbs_top_bench
`default_nettype wire
